/* File: src/sfb_bank1_regs.sv */
// How it works
// - The indirect window, counter low byte, status, pointer, upper latch and interrupt control answer at the same storage from either bank.
// - The upper byte of the program counter has no address of its own and is never read or written directly.
// - A 5-bit latch holds counter bits 12 to 8 and is copied into the upper counter when the low byte is written.
// - A master-clear pin reset or a watchdog reset loads the other-reset values, not the power-on values.
// - Both reset classes load all ones into option, port directions and timer period, and zeros into the low byte, latch, slave address and analog field.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sfb_bank1_regs (
  input  wire logic                 clk,              // Core clock, 100 MHz.
  input  wire logic                 rst_n,            // Power-on reset, synchronous.
  input  wire logic                 brownout_rst,     // Brown-out reset pulse.
  input  wire logic                 master_clear_rst, // Master-clear pin reset pulse.
  input  wire logic                 watchdog_rst,     // Watchdog timeout reset pulse.
  input  wire sfb_pkg::sfb_apb_req_t apb_req,         // APB request.
  output logic [31:0]               prdata,           // APB read data.
  output logic                      pready,           // APB ready.
  input  wire logic [7:0]           ind_rdata,        // Data memory byte at the pointer.
  output logic [7:0]                ind_addr,         // Data memory address from the pointer.
  output logic                      ind_we,           // Data memory write strobe.
  output logic [7:0]                ind_wdata,        // Data memory write byte.
  input  wire logic [2:0]           interrupt_control_flag_set,  // Hardware sets of interrupt flags 2:0.
  input  wire logic [5:0]           serial_status,    // Live serial port status bits.
  output sfb_pkg::sfb_ctrl_t        ctrl              // Register contents to the core.
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic sfb_pkg::sfb_sel_t decode_sel(input logic [11:0] addr);
    logic [7:0] idx;
    logic [7:0] up;
    logic       mirrored;
    idx = addr[9:2];
    up  = idx | sfb_pkg::BANK_SELECT_BIT;
    mirrored = (up == sfb_pkg::IDX_INDIRECT_DATA_WINDOW) ||
               (up == sfb_pkg::IDX_PROG_COUNTER_LOW) ||
               (up == sfb_pkg::IDX_CORE_STATUS) ||
               (up == sfb_pkg::IDX_INDIRECT_POINTER) ||
               (up == sfb_pkg::IDX_PROG_COUNTER_HIGH_LATCH) ||
               (up == sfb_pkg::IDX_INTERRUPT_CONTROL);
    decode_sel = sfb_pkg::SEL_NONE;
    if (addr[11:10] == 2'h0 && (idx[7] || mirrored))
    begin
      case (up)
        sfb_pkg::IDX_INDIRECT_DATA_WINDOW:    decode_sel = sfb_pkg::SEL_INDIRECT_DATA_WINDOW;
        sfb_pkg::IDX_OPTION_CONFIG:           decode_sel = sfb_pkg::SEL_OPTION;
        sfb_pkg::IDX_PROG_COUNTER_LOW:        decode_sel = sfb_pkg::SEL_PCL;
        sfb_pkg::IDX_CORE_STATUS:             decode_sel = sfb_pkg::SEL_STATUS;
        sfb_pkg::IDX_INDIRECT_POINTER:        decode_sel = sfb_pkg::SEL_FSR;
        sfb_pkg::IDX_PORT_A_DIRECTION:        decode_sel = sfb_pkg::SEL_TRIS_A;
        sfb_pkg::IDX_PORT_B_DIRECTION:        decode_sel = sfb_pkg::SEL_TRIS_B;
        sfb_pkg::IDX_PORT_C_DIRECTION:        decode_sel = sfb_pkg::SEL_TRIS_C;
        sfb_pkg::IDX_PROG_COUNTER_HIGH_LATCH: decode_sel = sfb_pkg::SEL_LATCH;
        sfb_pkg::IDX_INTERRUPT_CONTROL:       decode_sel = sfb_pkg::SEL_INTERRUPT_CONTROL;
        sfb_pkg::IDX_PERIPHERAL_IRQ_ENABLE:   decode_sel = sfb_pkg::SEL_PIE;
        sfb_pkg::IDX_POWER_RESET_FLAGS:       decode_sel = sfb_pkg::SEL_POWER_RESET_FLAGS;
        sfb_pkg::IDX_TIMER2_PERIOD:           decode_sel = sfb_pkg::SEL_PR2;
        sfb_pkg::IDX_SERIAL_SLAVE_ADDRESS:    decode_sel = sfb_pkg::SEL_SERIAL_SLAVE_ADDRESS;
        sfb_pkg::IDX_SERIAL_PORT_STATUS:      decode_sel = sfb_pkg::SEL_SERIAL_PORT_STATUS;
        sfb_pkg::IDX_ANALOG_PIN_CONFIG:       decode_sel = sfb_pkg::SEL_ADCON;
        default:                              decode_sel = sfb_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0]  option_reg;
  logic [7:0]  pcl_reg;
  logic [4:0]  pc_upper_reg;
  logic [7:0]  status_reg;
  logic [7:0]  fsr_reg;
  logic [5:0]  tris_a_reg;
  logic [7:0]  tris_b_reg;
  logic [7:0]  tris_c_reg;
  logic [4:0]  latch_reg;
  logic [7:0]  interrupt_control_reg;
  logic [7:0]  pie_reg;
  logic [1:0]  power_reset_flags_reg;
  logic [7:0]  pr2_reg;
  logic [7:0]  serial_slave_address_reg;
  logic [5:0]  serial_port_status_reg;
  logic [2:0]  adcon_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        ind_we_reg;
  logic [7:0]  ind_wdata_reg;
  logic [7:0]  interrupt_control_next;

  // ---------------------------------------------------------------------------
  // Bus handshake and strobes
  // ---------------------------------------------------------------------------
  // The select is a variable: its enum base is two-state, which a net may not carry.
  sfb_pkg::sfb_sel_t      sel;
  assign sel = decode_sel(apb_req.paddr);
  wire logic              access    = apb_req.psel && apb_req.penable;
  wire logic              wr_fire   = access && apb_req.pwrite && pready_reg;
  wire logic [7:0]        wbyte     = apb_req.pwdata[7:0];
  wire logic              power_rst = !rst_n || brownout_rst;
  wire logic              other_rst = master_clear_rst || watchdog_rst;
  wire logic              any_rst   = power_rst || other_rst;
  // A pointer at the window itself would loop back on the window; it reads zero.
  wire logic              ind_self  = (fsr_reg[6:0] == 7'h00);
  wire logic              pcl_wr    = wr_fire && (sel == sfb_pkg::SEL_PCL);
  wire logic              latch_wr  = wr_fire && (sel == sfb_pkg::SEL_LATCH);

  // The pc upper byte appears in no case below: it cannot be addressed.
  logic [7:0] rd_mux;
  always_comb
  begin
    case (sel)
      sfb_pkg::SEL_INDIRECT_DATA_WINDOW:    rd_mux = ind_self ? 8'h00 : ind_rdata;
      sfb_pkg::SEL_OPTION:  rd_mux = option_reg;
      sfb_pkg::SEL_PCL:     rd_mux = pcl_reg;
      sfb_pkg::SEL_STATUS:  rd_mux = status_reg;
      sfb_pkg::SEL_FSR:     rd_mux = fsr_reg;
      sfb_pkg::SEL_TRIS_A:  rd_mux = {2'h0, tris_a_reg};
      sfb_pkg::SEL_TRIS_B:  rd_mux = tris_b_reg;
      sfb_pkg::SEL_TRIS_C:  rd_mux = tris_c_reg;
      sfb_pkg::SEL_LATCH:   rd_mux = {3'h0, latch_reg};
      sfb_pkg::SEL_INTERRUPT_CONTROL:  rd_mux = interrupt_control_reg;
      sfb_pkg::SEL_PIE:     rd_mux = pie_reg;
      sfb_pkg::SEL_POWER_RESET_FLAGS:    rd_mux = {6'h00, power_reset_flags_reg};
      sfb_pkg::SEL_PR2:     rd_mux = pr2_reg;
      sfb_pkg::SEL_SERIAL_SLAVE_ADDRESS:  rd_mux = serial_slave_address_reg;
      sfb_pkg::SEL_SERIAL_PORT_STATUS: rd_mux = {2'h0, serial_port_status_reg};
      sfb_pkg::SEL_ADCON:   rd_mux = {5'h00, adcon_reg};
      default:              rd_mux = 8'h00;
    endcase
  end

  // One wait state keeps read data on a flop and lets the indirect byte settle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= access && !pready_reg;
      if (access && !pready_reg && !apb_req.pwrite)
        prdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge clk)
  begin
    if (any_rst)
    begin
      ind_we_reg    <= 1'b0;
      ind_wdata_reg <= 8'h00;
    end
    else
    begin
      ind_we_reg    <= wr_fire && (sel == sfb_pkg::SEL_INDIRECT_DATA_WINDOW) && !ind_self;
      ind_wdata_reg <= wbyte;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers loaded alike by both reset classes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (any_rst)
    begin
      option_reg <= sfb_pkg::RST_ALL_ONES;
      tris_a_reg <= sfb_pkg::RST_PORT_A_DIR;
      tris_b_reg <= sfb_pkg::RST_ALL_ONES;
      tris_c_reg <= sfb_pkg::RST_ALL_ONES;
      pr2_reg    <= sfb_pkg::RST_ALL_ONES;
      serial_slave_address_reg <= sfb_pkg::RST_ZERO_BYTE;
      adcon_reg  <= sfb_pkg::RST_ANALOG;
      pie_reg    <= sfb_pkg::RST_PIE;
      pcl_reg    <= sfb_pkg::RST_ZERO_BYTE;
      latch_reg  <= sfb_pkg::RST_LATCH;
    end
    else if (wr_fire)
    begin
      if (sel == sfb_pkg::SEL_OPTION) option_reg <= wbyte;
      if (sel == sfb_pkg::SEL_TRIS_A) tris_a_reg <= wbyte[5:0];
      if (sel == sfb_pkg::SEL_TRIS_B) tris_b_reg <= wbyte;
      if (sel == sfb_pkg::SEL_TRIS_C) tris_c_reg <= wbyte;
      if (sel == sfb_pkg::SEL_PR2)    pr2_reg    <= wbyte;
      if (sel == sfb_pkg::SEL_SERIAL_SLAVE_ADDRESS) serial_slave_address_reg <= wbyte;
      if (sel == sfb_pkg::SEL_ADCON)  adcon_reg  <= wbyte[2:0];
      if (sel == sfb_pkg::SEL_PIE)    pie_reg    <= wbyte & sfb_pkg::PIE_IMPL_MASK;
      if (sel == sfb_pkg::SEL_PCL)    pcl_reg    <= wbyte;
      if (sel == sfb_pkg::SEL_LATCH)  latch_reg  <= wbyte[4:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Program counter upper bits
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (any_rst)
      pc_upper_reg <= sfb_pkg::RST_LATCH;
    else if (pcl_wr)
      pc_upper_reg <= latch_reg;
  end

  // ---------------------------------------------------------------------------
  // Registers whose value depends on the reset class, and the serial status copy that every reset clears
  // ---------------------------------------------------------------------------
  // A hardware flag set in the same cycle as a software clear must survive.
  always_comb
  begin
    interrupt_control_next = interrupt_control_reg;
    if (wr_fire && sel == sfb_pkg::SEL_INTERRUPT_CONTROL)
      interrupt_control_next = wbyte;
    interrupt_control_next[2:0] = interrupt_control_next[2:0] | interrupt_control_flag_set;
  end

  always_ff @(posedge clk)
  begin
    if (power_rst)
    begin
      status_reg <= sfb_pkg::RST_STATUS_POWER;
      fsr_reg    <= sfb_pkg::RST_ZERO_BYTE;
      interrupt_control_reg <= sfb_pkg::RST_ZERO_BYTE;
    end
    else if (other_rst)
    begin
      status_reg[7:5] <= 3'h0;
      if (watchdog_rst)
        status_reg[sfb_pkg::STATUS_TIMEOUT_BIT] <= 1'b0;
      interrupt_control_reg[7:1] <= 7'h00;
    end
    else
    begin
      // Software is trusted to keep the two reserved bank bits clear.
      if (wr_fire && sel == sfb_pkg::SEL_STATUS)
        status_reg <= (wbyte & sfb_pkg::STATUS_SW_MASK) |
                      (status_reg & ~sfb_pkg::STATUS_SW_MASK);
      if (wr_fire && sel == sfb_pkg::SEL_FSR)
        fsr_reg <= wbyte;
      interrupt_control_reg <= interrupt_control_next;
    end
  end

  // Flags are cleared by the reset they report; software sets them back.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      power_reset_flags_reg <= sfb_pkg::RST_POWER_RESET_FLAGS_POWER;
    else if (brownout_rst)
      power_reset_flags_reg[sfb_pkg::POWER_RESET_FLAGS_BOR_BIT] <= 1'b0;
    else if (wr_fire && !other_rst && sel == sfb_pkg::SEL_POWER_RESET_FLAGS)
      power_reset_flags_reg <= wbyte[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (any_rst)
      serial_port_status_reg <= 6'h00;
    else
      serial_port_status_reg <= serial_status;
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign ind_addr  = fsr_reg;
  assign ind_we    = ind_we_reg;
  assign ind_wdata = ind_wdata_reg;

  assign ctrl.option_config         = option_reg;
  assign ctrl.port_a_direction      = tris_a_reg;
  assign ctrl.port_b_direction      = tris_b_reg;
  assign ctrl.port_c_direction      = tris_c_reg;
  assign ctrl.timer2_period         = pr2_reg;
  assign ctrl.serial_slave_address  = serial_slave_address_reg;
  assign ctrl.analog_pin_config     = adcon_reg;
  assign ctrl.peripheral_irq_enable = pie_reg;
  assign ctrl.interrupt_control     = interrupt_control_reg;
  assign ctrl.core_status           = status_reg;
  assign ctrl.power_reset_flags     = power_reset_flags_reg;
  assign ctrl.program_counter       = {pc_upper_reg, pcl_reg};

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  wire logic rd_take = access && !pready_reg && !apb_req.pwrite;

  mirror_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_take && (apb_req.paddr[11:2] == 10'h002) && !any_rst
    |=> prdata == {24'h00_0000, $past(pcl_reg)})
    else $error("low-bank counter byte read does not match storage");

  mirror_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_fire && (apb_req.paddr[11:2] == 10'h00a) && !any_rst
    |=> latch_reg == $past(apb_req.pwdata[4:0]))
    else $error("low-bank latch write missed the shared latch");

  upper_hidden_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !pcl_wr && !any_rst |=> $stable(pc_upper_reg))
    else $error("counter upper bits changed without a low byte write");

  latch_transfer_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    pcl_wr && !any_rst
    |=> ctrl.program_counter[12:8] == $past(latch_reg) ##1 $stable(pc_upper_reg))
    else $error("latch was not copied into counter upper bits");

  other_reset_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    watchdog_rst && !brownout_rst
    |=> status_reg[7:5] == 3'h0 && !status_reg[sfb_pkg::STATUS_TIMEOUT_BIT] &&
        $stable(fsr_reg) && $stable(power_reset_flags_reg))
    else $error("watchdog reset loaded wrong values");

  reset_values_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    any_rst |=> option_reg == 8'hff && tris_a_reg == 6'h3f && tris_c_reg == 8'hff &&
                pr2_reg == 8'hff && pcl_reg == 8'h00 && latch_reg == 5'h00 &&
                serial_slave_address_reg == 8'h00 && adcon_reg == 3'h0)
    else $error("reset values not loaded");

  unmapped_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_take && sel == sfb_pkg::SEL_NONE |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");

  ready_timing_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    access && !pready_reg |=> pready ##1 !pready)
    else $error("ready not given one cycle after access began");

endmodule
`default_nettype wire

/* File: src/sfb_pkg.sv */
`default_nettype none
package sfb_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_INDIRECT_DATA_WINDOW    = 8'h80;
  localparam logic [7:0] IDX_OPTION_CONFIG           = 8'h81;
  localparam logic [7:0] IDX_PROG_COUNTER_LOW        = 8'h82;
  localparam logic [7:0] IDX_CORE_STATUS             = 8'h83;
  localparam logic [7:0] IDX_INDIRECT_POINTER        = 8'h84;
  localparam logic [7:0] IDX_PORT_A_DIRECTION        = 8'h85;
  localparam logic [7:0] IDX_PORT_B_DIRECTION        = 8'h86;
  localparam logic [7:0] IDX_PORT_C_DIRECTION        = 8'h87;
  localparam logic [7:0] IDX_PROG_COUNTER_HIGH_LATCH = 8'h8a;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL       = 8'h8b;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLE   = 8'h8c;
  localparam logic [7:0] IDX_POWER_RESET_FLAGS       = 8'h8e;
  localparam logic [7:0] IDX_TIMER2_PERIOD           = 8'h92;
  localparam logic [7:0] IDX_SERIAL_SLAVE_ADDRESS    = 8'h93;
  localparam logic [7:0] IDX_SERIAL_PORT_STATUS      = 8'h94;
  localparam logic [7:0] IDX_ANALOG_PIN_CONFIG       = 8'h9f;
  localparam logic [7:0] BANK_SELECT_BIT             = 8'h80;

  // ---------------------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------------------
  localparam int         STATUS_TIMEOUT_BIT   = 4;
  localparam int         STATUS_POWERDOWN_BIT = 3;
  localparam logic [7:0] STATUS_SW_MASK       = 8'he7;
  localparam logic [7:0] PIE_IMPL_MASK        = 8'h4f;
  localparam int         POWER_RESET_FLAGS_POR_BIT         = 1;
  localparam int         POWER_RESET_FLAGS_BOR_BIT         = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_ALL_ONES      = 8'hff;
  localparam logic [5:0] RST_PORT_A_DIR    = 6'h3f;
  localparam logic [7:0] RST_ZERO_BYTE     = 8'h00;
  localparam logic [4:0] RST_LATCH         = 5'h00;
  localparam logic [2:0] RST_ANALOG        = 3'h0;
  localparam logic [7:0] RST_STATUS_POWER  = 8'h18;
  localparam logic [1:0] RST_POWER_RESET_FLAGS_POWER    = 2'h0;
  localparam logic [7:0] RST_PIE           = 8'h00;

  typedef enum {
    SEL_NONE, SEL_INDIRECT_DATA_WINDOW, SEL_OPTION, SEL_PCL, SEL_STATUS, SEL_FSR, SEL_TRIS_A,
    SEL_TRIS_B, SEL_TRIS_C, SEL_LATCH, SEL_INTERRUPT_CONTROL, SEL_PIE, SEL_POWER_RESET_FLAGS, SEL_PR2,
    SEL_SERIAL_SLAVE_ADDRESS, SEL_SERIAL_PORT_STATUS, SEL_ADCON
  } sfb_sel_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sfb_apb_req_t;

  typedef struct packed {
    logic [7:0]  option_config;
    logic [5:0]  port_a_direction;
    logic [7:0]  port_b_direction;
    logic [7:0]  port_c_direction;
    logic [7:0]  timer2_period;
    logic [7:0]  serial_slave_address;
    logic [2:0]  analog_pin_config;
    logic [7:0]  peripheral_irq_enable;
    logic [7:0]  interrupt_control;
    logic [7:0]  core_status;
    logic [1:0]  power_reset_flags;
    logic [12:0] program_counter;
  } sfb_ctrl_t;

endpackage
`default_nettype wire

/* File: tb/sfr_bank1_decode_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sfr_bank1_decode_tb_top;
  // ---------------------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------------------
  logic                  clk;
  logic                  rst_n;
  logic                  brownout_rst;
  logic                  master_clear_rst;
  logic                  watchdog_rst;
  sfb_pkg::sfb_apb_req_t apb_req;
  logic [31:0]           prdata;
  logic                  pready;
  logic [7:0]            ind_rdata;
  logic [7:0]            ind_addr;
  logic                  ind_we;
  logic [7:0]            ind_wdata;
  logic [2:0]            interrupt_control_flag_set;
  logic [5:0]            serial_status;
  sfb_pkg::sfb_ctrl_t    ctrl;
  sfb_pkg::sfb_ctrl_t    snap;
  int                    errors = 0;
  int                    num_checks = 0;
  int                    cycles = 0;
  logic [31:0]           rd;

  localparam logic [7:0] R6_IDX [9] = '{8'h81, 8'h85, 8'h86, 8'h87, 8'h92, 8'h82, 8'h8a, 8'h93, 8'h9f};
  localparam logic [7:0] R6_VAL [9] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

  // A memory stand-in whose data depends on the address, so a stale pointer shows up.
  assign ind_rdata = ind_addr ^ 8'h7b;

  sfb_bank1_regs u_sfb_bank1_regs (
    .clk              (clk),
    .rst_n            (rst_n),
    .brownout_rst     (brownout_rst),
    .master_clear_rst (master_clear_rst),
    .watchdog_rst     (watchdog_rst),
    .apb_req          (apb_req),
    .prdata           (prdata),
    .pready           (pready),
    .ind_rdata        (ind_rdata),
    .ind_addr         (ind_addr),
    .ind_we           (ind_we),
    .ind_wdata        (ind_wdata),
    .interrupt_control_flag_set  (interrupt_control_flag_set),
    .serial_status    (serial_status),
    .ctrl             (ctrl)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole run needs well under a thousand cycles; the ceiling leaves ample margin.
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    $display("Checks: %0d, mismatches: %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Pready and read data are taken at the rising edge, before the flops move on it.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00},
                 pwdata: {24'h000000, wd}};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      check("pready", 32'h1, 32'h0);
    rd = prdata;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check($sformatf("reg_%h", idx), {24'h000000, exp}, rd);
  endtask

  task automatic chk_r06();
    for (int i = 0; i < 9; i++)
      rd_chk(R6_IDX[i], R6_VAL[i]);
  endtask

  task automatic dirty();
    for (int i = 0; i < 9; i++)
      wr(R6_IDX[i], 8'h5a);
  endtask

  task automatic pulse(input logic [2:0] k);
    @(posedge clk);
    {brownout_rst, master_clear_rst, watchdog_rst} <= k;
    @(posedge clk);
    {brownout_rst, master_clear_rst, watchdog_rst} <= 3'b000;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_power_values();
    chk_r06();
    rd_chk(8'h94, 8'h2a);
    @(negedge clk);
    check("pc", 32'h0, {19'h0, ctrl.program_counter});
  endtask

  task automatic t_mirror();
    wr(8'h84, 8'h21);
    rd_chk(8'h04, 8'h21);
    wr(8'h0a, 8'h15);
    rd_chk(8'h8a, 8'h15);
    wr(8'h0b, 8'hf0);
    rd_chk(8'h8b, 8'hf0);
    // A hardware flag raised while software clears the register must survive.
    interrupt_control_flag_set <= 3'h1;
    wr(8'h0b, 8'h00);
    interrupt_control_flag_set <= 3'h0;
    rd_chk(8'h8b, 8'h01);
    wr(8'h8c, 8'hff);
    rd_chk(8'h8c, 8'h4f);
    // The two bank bits are written as zero; bits 4:3 are not writable.
    wr(8'h03, 8'h07);
    rd_chk(8'h83, 8'h1f);
  endtask

  task automatic t_pc();
    @(negedge clk);
    check("pc_before", 32'h0, {19'h0, ctrl.program_counter});
    wr(8'h02, 8'h34);
    @(negedge clk);
    check("pc_after", 32'h1534, {19'h0, ctrl.program_counter});
    rd_chk(8'h82, 8'h34);
    rd_chk(8'h02, 8'h34);
    wr(8'h8a, 8'h03);
    @(negedge clk);
    check("pc_latch_only", 32'h1534, {19'h0, ctrl.program_counter});
  endtask

  task automatic t_window();
    rd_chk(8'h80, 8'h5a);
    rd_chk(8'h00, 8'h5a);
    wr(8'h00, 8'hc3);
    @(negedge clk);
    check("ind_we", 32'h1, {31'h0, ind_we});
    check("ind_wdata", 32'hc3, {24'h0, ind_wdata});
    check("ind_addr", 32'h21, {24'h0, ind_addr});
  endtask

  task automatic t_unmapped();
    logic [7:0] holes [6];
    holes = '{8'h88, 8'h8d, 8'h8f, 8'h95, 8'h9e, 8'h01};
    @(negedge clk);
    snap = ctrl;
    foreach (holes[i])
      wr(holes[i], 8'haa);
    @(negedge clk);
    check("ctrl_kept", 32'h0, {31'h0, ctrl !== snap});
    foreach (holes[i])
      rd_chk(holes[i], 8'h00);
  endtask

  task automatic t_reset_classes();
    wr(8'h8e, 8'h03);
    dirty();
    pulse(3'b010);
    chk_r06();
    rd_chk(8'h84, 8'h21);
    rd_chk(8'h83, 8'h1f);
    rd_chk(8'h8b, 8'h01);
    rd_chk(8'h8e, 8'h03);
    dirty();
    pulse(3'b001);
    chk_r06();
    rd_chk(8'h83, 8'h0f);
    dirty();
    pulse(3'b100);
    chk_r06();
    rd_chk(8'h84, 8'h00);
    rd_chk(8'h83, 8'h18);
    rd_chk(8'h8b, 8'h00);
    rd_chk(8'h8e, 8'h02);
  endtask

  initial
  begin
    rst_n = 1'b0;
    brownout_rst = 1'b0;
    master_clear_rst = 1'b0;
    watchdog_rst = 1'b0;
    apb_req = '0;
    interrupt_control_flag_set = 3'h0;
    serial_status = 6'h2a;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_power_values();
    t_mirror();
    t_pc();
    t_window();
    t_unmapped();
    t_reset_classes();
    finish_test();
  end
endmodule
`default_nettype wire
